//--- verilog/ivm_interrupt_vector_mapping.sv
// Interrupt source mapping, priority, wake-up and vector fetch sequencing
`timescale 1ns/1ps
module ivm_interrupt_vector_mapping #(
  parameter int PINS = ivm_pkg::NUM_INT_PINS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // Reset pin and variant strap
  input wire logic reset_pin_n,
  input wire logic flash_variant,
  // Interrupt-capable pins
  input wire logic [PINS-1:0] int_pin,
  input wire logic [PINS-1:0] pin_dir,
  input wire logic [PINS-1:0] pin_opt,
  output ivm_pkg::ivm_pin_cfg_type pin_cfg,
  // Peripheral requests
  input wire ivm_pkg::ivm_periph_req_type periph_req,
  // Core side
  input wire logic trap_req,
  input wire logic core_ready,
  input wire logic cpu_int_mask,
  input wire logic halt_mode,
  input wire logic active_halt_mode,
  output logic wake,
  output logic in_reset,
  output ivm_pkg::ivm_serve_type served,
  output logic [ivm_pkg::NUM_SLOTS-1:0] src_ack,
  output logic pc_load,
  output logic [15:0] pc_value,
  // Vector memory port
  output ivm_pkg::ivm_fetch_type vec_fetch,
  input wire logic [7:0] vec_rd_data
);

  typedef enum logic [1:0] {ST_IDLE, ST_RD_HI, ST_RD_LO, ST_LOAD} ivm_state_type;

  if (PINS != ivm_pkg::NUM_INT_PINS) begin : g_check
    $error("ivm_interrupt_vector_mapping: PINS must match the pin table");
  end

  // ==========================================================================
  // Declarations
  logic [PINS-1:0] pin_meta, pin_sync, pin_last;
  logic [PINS-1:0] next_pin_meta, next_pin_sync, next_pin_last;
  logic rst_meta, rst_sync, next_rst_meta, next_rst_sync, next_in_reset;
  logic flash_mode, strap_taken, next_flash_mode, next_strap_taken;
  logic [3:0] ext_pend, next_ext_pend, ext_set, ext_clr;
  logic trap_pend, rst_pend, next_trap_pend, next_rst_pend;
  logic rst_hold, go_reset, go_trap, go_slot, next_wake;
  logic [PINS-1:0] pin_fall;
  logic [ivm_pkg::NUM_SLOTS-1:0] raw_pend, pend_vec, ahalt_mask;
  logic pick_valid;
  logic [ivm_pkg::SLOT_BITS-1:0] pick_index;
  ivm_state_type state, next_state;
  logic [15:0] vec, next_vec, next_pc_value;
  logic [7:0] hi_byte, next_hi_byte;
  logic next_pc_load;
  logic [ivm_pkg::NUM_SLOTS-1:0] next_src_ack;
  ivm_pkg::ivm_serve_type next_served;
  ivm_pkg::ivm_fetch_type next_fetch;

  // ==========================================================================
  // Input synchronisers
  always_comb begin
    next_pin_meta = int_pin;
    next_pin_sync = pin_meta;
    next_pin_last = pin_sync;
    next_rst_meta = reset_pin_n;
    next_rst_sync = rst_meta;
    next_in_reset = !rst_sync;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= ivm_pkg::PIN_IDLE_LEVEL;
      pin_sync <= ivm_pkg::PIN_IDLE_LEVEL;
      pin_last <= ivm_pkg::PIN_IDLE_LEVEL;
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
      in_reset <= 1'b0;
    end else if (ce) begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      pin_last <= next_pin_last;
      rst_meta <= next_rst_meta;
      rst_sync <= next_rst_sync;
      in_reset <= next_in_reset;
    end
  end

  assign rst_hold = !rst_sync;

  // ==========================================================================
  // Variant strap, caught on the first enabled edge after reset
  always_comb begin
    next_flash_mode = strap_taken ? flash_mode : flash_variant;
    next_strap_taken = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flash_mode <= 1'b0;
      strap_taken <= 1'b0;
    end else if (ce) begin
      flash_mode <= next_flash_mode;
      strap_taken <= next_strap_taken;
    end
  end

  // ==========================================================================
  // Pin configuration
  ivm_pin_cfg #(
    .PINS(PINS)
  ) u_pin_cfg (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .hold_reset(rst_hold),
    .pin_dir(pin_dir),
    .pin_opt(pin_opt),
    .cfg(pin_cfg)
  );

  // ==========================================================================
  // Pending sources
  assign pin_fall = pin_last & ~pin_sync & pin_cfg.int_en;

  always_comb begin
    for (int g = 0; g < 4; g++) begin
      ext_set[g] = |(pin_fall & ivm_pkg::EXT_GROUP_PINS[g]);
      ext_clr[g] = go_slot && (pick_index == ivm_pkg::SLOT_EXT_A_LOW + 4'(g));
    end
    next_ext_pend = (ext_pend & ~ext_clr) | ext_set;
    next_trap_pend = (trap_pend && !go_trap) || trap_req;
    next_rst_pend = (rst_pend && !go_reset) || rst_hold;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ext_pend <= '0;
      trap_pend <= 1'b0;
      rst_pend <= 1'b1;
    end else if (ce) begin
      ext_pend <= next_ext_pend;
      trap_pend <= next_trap_pend;
      rst_pend <= next_rst_pend;
    end
  end

  always_comb begin
    raw_pend = '0;
    raw_pend[ivm_pkg::SLOT_TIMEBASE] = periph_req.timebase;
    raw_pend[ivm_pkg::SLOT_EXT_A_LOW] = ext_pend[0];
    raw_pend[ivm_pkg::SLOT_EXT_F_LOW] = ext_pend[1];
    raw_pend[ivm_pkg::SLOT_EXT_B_LOW] = ext_pend[2];
    raw_pend[ivm_pkg::SLOT_EXT_B_HIGH] = ext_pend[3];
    raw_pend[ivm_pkg::SLOT_SPI] = periph_req.spi;
    raw_pend[ivm_pkg::SLOT_TIMER1] = periph_req.timer1;
    raw_pend[ivm_pkg::SLOT_TIMER2] = periph_req.timer2;
    raw_pend[ivm_pkg::SLOT_SCI] = periph_req.sci;
    pend_vec = raw_pend & ivm_pkg::SLOT_USED;
  end

  ivm_prio_pick #(
    .WIDTH(ivm_pkg::NUM_SLOTS)
  ) u_prio_pick (
    .req(pend_vec),
    .valid(pick_valid),
    .index(pick_index)
  );

  // ==========================================================================
  // Acceptance: reset, then trap, then maskable slots
  always_comb begin
    go_reset = (state == ST_IDLE) && !rst_hold && rst_pend;
    go_trap = (state == ST_IDLE) && !rst_hold && !rst_pend && core_ready && trap_pend;
    go_slot = (state == ST_IDLE) && !rst_hold && !rst_pend && core_ready && !trap_pend &&
              pick_valid && !cpu_int_mask;
  end

  // ==========================================================================
  // Vector fetch sequencer
  always_comb begin
    next_state = state;
    next_vec = vec;
    next_served = served;
    next_src_ack = '0;
    next_fetch = '0;
    next_hi_byte = hi_byte;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    case (state)
      ST_IDLE: begin
        if (go_reset) begin
          next_vec = ivm_pkg::VEC_RESET;
          next_served = '{is_reset: 1'b1, is_trap: 1'b0, slot: '0};
        end else if (go_trap) begin
          next_vec = ivm_pkg::VEC_TRAP;
          next_served = '{is_reset: 1'b0, is_trap: 1'b1, slot: '0};
        end else if (go_slot) begin
          next_vec = ivm_pkg::SLOT_VECTOR[pick_index];
          next_served = '{is_reset: 1'b0, is_trap: 1'b0, slot: pick_index};
          next_src_ack[pick_index] = 1'b1;
        end
        if (go_reset || go_trap || go_slot) begin
          next_fetch = '{rd_en: 1'b1, addr: next_vec};
          next_state = ST_RD_HI;
        end
      end
      ST_RD_HI: begin
        next_fetch = '{rd_en: 1'b1, addr: vec + ivm_pkg::VEC_LOW_BYTE_STEP};
        next_state = ST_RD_LO;
      end
      ST_RD_LO: begin
        next_hi_byte = vec_rd_data;
        next_state = ST_LOAD;
      end
      ST_LOAD: begin
        next_pc_value = {hi_byte, vec_rd_data};
        next_pc_load = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (rst_hold) begin
      next_state = ST_IDLE;
      next_fetch = '0;
      next_src_ack = '0;
      next_pc_load = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      vec <= '0;
      served <= '0;
      src_ack <= '0;
      vec_fetch <= '0;
      hi_byte <= '0;
      pc_load <= 1'b0;
      pc_value <= '0;
    end else if (ce) begin
      state <= next_state;
      vec <= next_vec;
      served <= next_served;
      src_ack <= next_src_ack;
      vec_fetch <= next_fetch;
      hi_byte <= next_hi_byte;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
    end
  end

  // ==========================================================================
  // Wake-up from halt and active-halt
  always_comb begin
    ahalt_mask = flash_mode ? ivm_pkg::SLOT_AHALT_FLASH : ivm_pkg::SLOT_AHALT_EXIT;
    next_wake = (halt_mode && (rst_pend || |(pend_vec & ivm_pkg::SLOT_HALT_EXIT))) ||
                (active_halt_mode && (rst_pend || |(pend_vec & ahalt_mask)));
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake <= 1'b0;
    end else if (ce) begin
      wake <= next_wake;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking ivm_cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn || !ce);

  pin_reset_cfg_a: assert property (in_reset |-> (pin_cfg == '0))
    else $error("pins left reset configuration while in reset");
  reset_vector_a: assert property (go_reset |=> vec_fetch.rd_en && vec_fetch.addr == ivm_pkg::VEC_RESET)
    else $error("reset did not fetch its vector");
  trap_vector_a: assert property (go_trap |=> vec_fetch.rd_en && vec_fetch.addr == ivm_pkg::VEC_TRAP)
    else $error("trap did not fetch its vector");
  unused_slot_a: assert property (go_slot |-> ivm_pkg::SLOT_USED[pick_index])
    else $error("an unused slot was served");
  timebase_halt_a: assert property ((halt_mode && !active_halt_mode && !rst_pend &&
      (pend_vec & ivm_pkg::SLOT_HALT_EXIT) == '0) |=> !wake)
    else $error("wake from halt without a halt-exit source");
  ext_wake_a: assert property ((halt_mode && ext_pend[0]) |=> wake)
    else $error("port A group failed to wake");
  priority_order_a: assert property (go_slot |->
      (pend_vec & ((11'h001 << pick_index) - 11'h001)) == '0 ##1 served.slot == $past(pick_index))
    else $error("a lower-priority slot was served first");
  pullup_mask_a: assert property (pin_cfg.pull_up == (pin_cfg.int_en & ivm_pkg::PIN_PULLUP_MASK))
    else $error("pull-up mismatch on interrupt pin");
  reset_pin_nmi_a: assert property ($rose(rst_sync) |-> go_reset ##1 vec_fetch.rd_en)
    else $error("reset pin release did not start the reset fetch");
  sci_lowest_a: assert property ((go_slot && pick_index == ivm_pkg::SLOT_SCI) |-> $onehot(pend_vec))
    else $error("serial comm served ahead of another source");
  flash_wake_a: assert property ((flash_mode && active_halt_mode && !halt_mode && !rst_pend &&
      !pend_vec[ivm_pkg::SLOT_TIMEBASE]) |=> !wake)
    else $error("flash variant woke from active-halt on a forbidden source");
  byte_order_a: assert property ((state == ST_RD_HI && !rst_hold) |=>
      vec_fetch.addr == $past(vec_fetch.addr) + ivm_pkg::VEC_LOW_BYTE_STEP)
    else $error("low byte not fetched from the upper address");
  pc_value_a: assert property (pc_load |-> pc_value == {$past(vec_rd_data, 2), $past(vec_rd_data)})
    else $error("program counter bytes swapped");

  reset_fetch_c: cover property (go_reset ##3 pc_load);
  trap_fetch_c: cover property (go_trap ##3 pc_load);
  ext_served_c: cover property (go_slot && pick_index == ivm_pkg::SLOT_EXT_B_LOW);
  ahalt_wake_c: cover property (active_halt_mode && wake);

endmodule : ivm_interrupt_vector_mapping

//--- verilog/ivm_pkg.sv
// Constants and types shared by the interrupt vector mapping block
package ivm_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_SLOTS = 11;
  localparam int NUM_INT_PINS = 9;
  localparam int SLOT_BITS = 4;

  // ==========================================================================
  // Fixed vectors
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_LOW_BYTE_STEP = 16'h0001;

  // ==========================================================================
  // Slot numbers
  localparam logic [3:0] SLOT_TIMEBASE = 4'h1;
  localparam logic [3:0] SLOT_EXT_A_LOW = 4'h2;
  localparam logic [3:0] SLOT_EXT_F_LOW = 4'h3;
  localparam logic [3:0] SLOT_EXT_B_LOW = 4'h4;
  localparam logic [3:0] SLOT_EXT_B_HIGH = 4'h5;
  localparam logic [3:0] SLOT_SPI = 4'h7;
  localparam logic [3:0] SLOT_TIMER1 = 4'h8;
  localparam logic [3:0] SLOT_TIMER2 = 4'h9;
  localparam logic [3:0] SLOT_SCI = 4'ha;

  // ==========================================================================
  // Vector table, slot 10 first
  localparam logic [NUM_SLOTS-1:0][15:0] SLOT_VECTOR = {
    16'hffe6, 16'hffe8, 16'hffea, 16'hffec, 16'hffee, 16'hfff0,
    16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa};

  // ==========================================================================
  // Slot attribute masks
  // Slots 0 and 6 carry no source
  localparam logic [NUM_SLOTS-1:0] SLOT_USED = 11'h7be;
  // Halt exit: pin groups and serial peripheral only; timers never
  localparam logic [NUM_SLOTS-1:0] SLOT_HALT_EXIT = 11'h0bc;
  // Active-halt exit: time base plus halt-exit sources
  localparam logic [NUM_SLOTS-1:0] SLOT_AHALT_EXIT = 11'h0be;
  // Active-halt exit on flash variants: time base only
  localparam logic [NUM_SLOTS-1:0] SLOT_AHALT_FLASH = 11'h002;

  // ==========================================================================
  // Interrupt pins: 0 A3, 1 F0, 2 F1, 3 F2, 4 B0, 5 B1, 6 B2, 7 B3, 8 B4
  localparam logic [NUM_INT_PINS-1:0] PIN_PULLUP_MASK = 9'h176;
  localparam logic [3:0][NUM_INT_PINS-1:0] EXT_GROUP_PINS = {9'h100, 9'h0f0, 9'h00e, 9'h001};
  localparam logic [NUM_INT_PINS-1:0] PIN_IDLE_LEVEL = 9'h1ff;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic rd_en;
    logic [15:0] addr;
  } ivm_fetch_type;

  typedef struct packed {
    logic is_reset;
    logic is_trap;
    logic [SLOT_BITS-1:0] slot;
  } ivm_serve_type;

  typedef struct packed {
    logic timebase;
    logic spi;
    logic timer1;
    logic timer2;
    logic sci;
  } ivm_periph_req_type;

  typedef struct packed {
    logic [NUM_INT_PINS-1:0] out_en;
    logic [NUM_INT_PINS-1:0] push_pull;
    logic [NUM_INT_PINS-1:0] pull_up;
    logic [NUM_INT_PINS-1:0] int_en;
  } ivm_pin_cfg_type;

endpackage : ivm_pkg

//--- verilog/ivm_prio_pick.sv
// Fixed-priority picker: lowest set index wins
`timescale 1ns/1ps
module ivm_prio_pick #(
  parameter int WIDTH = ivm_pkg::NUM_SLOTS
) (
  // Requests
  input wire logic [WIDTH-1:0] req,
  // Winner
  output logic valid,
  output logic [ivm_pkg::SLOT_BITS-1:0] index
);

  logic [WIDTH:0] below;
  logic [WIDTH:0][ivm_pkg::SLOT_BITS-1:0] idx_or;

  if (WIDTH < 2 || WIDTH > (1 << ivm_pkg::SLOT_BITS)) begin : g_check
    $error("ivm_prio_pick: WIDTH out of range");
  end

  assign below[0] = 1'b0;
  assign idx_or[0] = '0;

  // ==========================================================================
  // Priority chain
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign below[i+1] = below[i] | req[i];
    assign idx_or[i+1] = idx_or[i] |
      ((req[i] && !below[i]) ? ivm_pkg::SLOT_BITS'(i) : '0);
  end

  assign valid = below[WIDTH];
  assign index = idx_or[WIDTH];

endmodule : ivm_prio_pick

//--- verilog/ivm_pin_cfg.sv
// Interrupt-capable pin configuration decode with reset override
`timescale 1ns/1ps
module ivm_pin_cfg #(
  parameter int PINS = ivm_pkg::NUM_INT_PINS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // Reset state
  input wire logic hold_reset,
  // Software configuration
  input wire logic [PINS-1:0] pin_dir,
  input wire logic [PINS-1:0] pin_opt,
  // Decoded configuration
  output ivm_pkg::ivm_pin_cfg_type cfg
);

  ivm_pkg::ivm_pin_cfg_type next_cfg;

  if (PINS != ivm_pkg::NUM_INT_PINS) begin : g_check
    $error("ivm_pin_cfg: PINS must match the pin table");
  end

  // ==========================================================================
  // Decode
  always_comb begin
    next_cfg.out_en = pin_dir;
    next_cfg.push_pull = pin_dir & pin_opt;
    next_cfg.int_en = ~pin_dir & pin_opt;
    next_cfg.pull_up = ~pin_dir & pin_opt & ivm_pkg::PIN_PULLUP_MASK;
    if (hold_reset) begin
      next_cfg = '0;
    end
  end

  // ==========================================================================
  // Register, floating input from reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= '0;
    end else if (ce) begin
      cfg <= next_cfg;
    end
  end

endmodule : ivm_pin_cfg

//--- tb/ivm_interrupt_vector_mapping_bench.sv
// Self-checking bench for the interrupt vector mapping block
`timescale 1ns/1ps
module ivm_interrupt_vector_mapping_bench;
  // ==========================================================================
  // Signals
  logic sys_clk, resetn, ce, reset_pin_n, flash_variant;
  logic [8:0] int_pin, pin_dir, pin_opt;
  ivm_pkg::ivm_pin_cfg_type pin_cfg;
  ivm_pkg::ivm_periph_req_type periph_req;
  logic trap_req, core_ready, cpu_int_mask, halt_mode, active_halt_mode;
  logic wake, in_reset, pc_load;
  ivm_pkg::ivm_serve_type served;
  logic [10:0] src_ack;
  logic [15:0] pc_value;
  ivm_pkg::ivm_fetch_type vec_fetch;
  logic [7:0] vec_rd_data = 8'h00;
  logic mem_en = 1'h0;
  logic [15:0] mem_addr = 16'h0000;
  int err_count, checked;
  int cycles = 0;

  // ==========================================================================
  // Design
  ivm_interrupt_vector_mapping #(.PINS(9)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .reset_pin_n(reset_pin_n),
    .flash_variant(flash_variant), .int_pin(int_pin), .pin_dir(pin_dir), .pin_opt(pin_opt),
    .pin_cfg(pin_cfg), .periph_req(periph_req), .trap_req(trap_req), .core_ready(core_ready),
    .cpu_int_mask(cpu_int_mask), .halt_mode(halt_mode), .active_halt_mode(active_halt_mode),
    .wake(wake), .in_reset(in_reset), .served(served), .src_ack(src_ack), .pc_load(pc_load),
    .pc_value(pc_value), .vec_fetch(vec_fetch), .vec_rd_data(vec_rd_data)
  );

  // ==========================================================================
  // Clock, vector memory and timeout
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : mem_byte

  function automatic logic [15:0] vec_of(input int s);
    return 16'hfffa - 16'(2 * s);
  endfunction : vec_of

  // One cycle read latency, data scrambled when not read
  always @(posedge sys_clk) begin
    mem_en <= vec_fetch.rd_en;
    mem_addr <= vec_fetch.addr;
  end

  always @(negedge sys_clk) begin
    vec_rd_data <= (mem_en === 1'h1) ? mem_byte(mem_addr) : ~vec_rd_data;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      report_and_stop();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // Follows one vector fetch from request to program counter load
  task automatic serve(input logic [15:0] v, input logic rst, input logic trp, input logic [3:0] slot);
    int n;
    logic [10:0] ack;
    n = 0;
    ack = (rst | trp) ? 11'h000 : (11'h001 << slot);
    while (vec_fetch.rd_en !== 1'h1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    cmp(vec_fetch.addr, v, "first vector address");
    cmp(src_ack, ack, "source acknowledge");
    cmp(served, {rst, trp, slot}, "served source");
    case (slot)
      4'h1: periph_req.timebase = 1'h0;
      4'h7: periph_req.spi = 1'h0;
      4'h8: periph_req.timer1 = 1'h0;
      4'h9: periph_req.timer2 = 1'h0;
      4'ha: periph_req.sci = 1'h0;
      default: ;
    endcase
    @(negedge sys_clk);
    cmp({vec_fetch.rd_en, vec_fetch.addr}, {1'h1, v + 16'h0001}, "second vector address");
    repeat (2) @(negedge sys_clk);
    cmp(pc_load, 1'h1, "program counter load");
    cmp(pc_value, {mem_byte(v), mem_byte(v + 16'h0001)}, "program counter value");
    @(negedge sys_clk);
  endtask : serve

  task automatic wake_chk(input logic h, input logic a, input logic [4:0] p, input logic exp);
    halt_mode = h;
    active_halt_mode = a;
    periph_req = p;
    repeat (3) @(negedge sys_clk);
    cmp(wake, exp, "wake level");
    periph_req = '0;
    halt_mode = 1'h0;
    active_halt_mode = 1'h0;
    repeat (2) @(negedge sys_clk);
  endtask : wake_chk

  task automatic cfg_chk(input logic [8:0] d, input logic [8:0] o, input logic [35:0] exp);
    pin_dir = d;
    pin_opt = o;
    repeat (2) @(negedge sys_clk);
    cmp(pin_cfg, exp, "pin configuration");
  endtask : cfg_chk

  // ==========================================================================
  // Scenarios
  task automatic test_pin_cfg();
    cfg_chk(9'h1ff, 9'h0aa, {9'h1ff, 9'h0aa, 9'h000, 9'h000});
    cfg_chk(9'h0f0, 9'h0ff, {9'h0f0, 9'h0f0, 9'h006, 9'h00f});
    cfg_chk(9'h000, 9'h1ff, {9'h000, 9'h000, 9'h176, 9'h1ff});
  endtask : test_pin_cfg

  task automatic test_reset_pin();
    reset_pin_n = 1'h0;
    halt_mode = 1'h1;
    repeat (5) @(negedge sys_clk);
    cmp(wake, 1'h1, "reset wakes halt");
    halt_mode = 1'h0;
    cmp(in_reset, 1'h1, "reset pin seen");
    cmp(pin_cfg, 36'h0, "config held in reset");
    cmp(pc_load, 1'h0, "no load in reset");
    reset_pin_n = 1'h1;
    serve(16'hfffe, 1'h1, 1'h0, 4'h0);
    cmp(pin_cfg, {9'h000, 9'h000, 9'h176, 9'h1ff}, "config after reset");
  endtask : test_reset_pin

  task automatic test_trap_prio();
    periph_req = '1;
    @(negedge sys_clk);
    trap_req = 1'h1;
    @(negedge sys_clk);
    trap_req = 1'h0;
    serve(16'hfffc, 1'h0, 1'h1, 4'h0);
    cpu_int_mask = 1'h0;
    serve(vec_of(1), 1'h0, 1'h0, 4'h1);
    serve(vec_of(7), 1'h0, 1'h0, 4'h7);
    serve(vec_of(8), 1'h0, 1'h0, 4'h8);
    serve(vec_of(9), 1'h0, 1'h0, 4'h9);
    serve(vec_of(10), 1'h0, 1'h0, 4'ha);
    cpu_int_mask = 1'h1;
  endtask : test_trap_prio

  task automatic test_ext_groups();
    int_pin = 9'h076;
    repeat (6) @(negedge sys_clk);
    halt_mode = 1'h1;
    repeat (2) @(negedge sys_clk);
    cmp(wake, 1'h1, "pin group wakes halt");
    halt_mode = 1'h0;
    cpu_int_mask = 1'h0;
    for (int s = 2; s < 6; s++) begin
      serve(vec_of(s), 1'h0, 1'h0, 4'(s));
    end
    int_pin = '1;
    cpu_int_mask = 1'h1;
  endtask : test_ext_groups

  task automatic test_refused();
    halt_mode = 1'h1;
    pin_dir = 9'h1ff;
    repeat (2) @(negedge sys_clk);
    int_pin = 9'h000;
    repeat (5) @(negedge sys_clk);
    cmp(wake, 1'h0, "output pin raised an interrupt");
    int_pin = '1;
    repeat (3) @(negedge sys_clk);
    pin_dir = 9'h000;
    halt_mode = 1'h0;
    repeat (2) @(negedge sys_clk);
  endtask : test_refused

  task automatic test_freeze();
    ce = 1'h0;
    cpu_int_mask = 1'h0;
    periph_req.timebase = 1'h1;
    repeat (3) begin
      @(negedge sys_clk);
      cmp({vec_fetch.rd_en, pc_load}, 2'h0, "fetch moved while frozen");
    end
    ce = 1'h1;
    serve(16'hfff8, 1'h0, 1'h0, 4'h1);
    cpu_int_mask = 1'h1;
  endtask : test_freeze

  task automatic test_wake();
    core_ready = 1'h0;
    wake_chk(1'h1, 1'h0, 5'h10, 1'h0);
    wake_chk(1'h0, 1'h1, 5'h10, 1'h1);
    wake_chk(1'h1, 1'h0, 5'h08, 1'h1);
    wake_chk(1'h0, 1'h1, 5'h08, 1'h1);
    wake_chk(1'h1, 1'h0, 5'h04, 1'h0);
    wake_chk(1'h0, 1'h1, 5'h04, 1'h0);
    wake_chk(1'h1, 1'h0, 5'h02, 1'h0);
    wake_chk(1'h0, 1'h1, 5'h02, 1'h0);
    wake_chk(1'h0, 1'h1, 5'h01, 1'h0);
    halt_mode = 1'h1;
    trap_req = 1'h1;
    @(negedge sys_clk);
    trap_req = 1'h0;
    repeat (2) @(negedge sys_clk);
    cmp(wake, 1'h0, "trap does not wake");
    halt_mode = 1'h0;
    core_ready = 1'h1;
    serve(16'hfffc, 1'h0, 1'h1, 4'h0);
  endtask : test_wake

  task automatic test_flash();
    resetn = 1'h0;
    flash_variant = 1'h1;
    repeat (2) @(negedge sys_clk);
    resetn = 1'h1;
    serve(16'hfffe, 1'h1, 1'h0, 4'h0);
    core_ready = 1'h0;
    wake_chk(1'h0, 1'h1, 5'h08, 1'h0);
    wake_chk(1'h0, 1'h1, 5'h10, 1'h1);
  endtask : test_flash

  // ==========================================================================
  // Main sequence
  initial begin
    resetn = 1'h0;
    ce = 1'h1;
    reset_pin_n = 1'h1;
    flash_variant = 1'h0;
    int_pin = '1;
    pin_dir = 9'h000;
    pin_opt = 9'h1ff;
    periph_req = '0;
    trap_req = 1'h0;
    core_ready = 1'h1;
    cpu_int_mask = 1'h1;
    halt_mode = 1'h0;
    active_halt_mode = 1'h0;
    err_count = 0;
    checked = 0;
    repeat (8) @(negedge sys_clk);
    cmp(pin_cfg, 36'h0, "config in system reset");
    resetn = 1'h1;
    serve(16'hfffe, 1'h1, 1'h0, 4'h0);
    test_pin_cfg();
    test_reset_pin();
    test_trap_prio();
    test_ext_groups();
    test_refused();
    test_freeze();
    test_wake();
    test_flash();
    report_and_stop();
  end
endmodule : ivm_interrupt_vector_mapping_bench
